// ===== hdl/dmap_data_path.sv
// data, address and barrier path of a debug memory access port
`timescale 1ns/1ps
`include "dmap_consts.svh"

// What this block does
// - byte or halfword data port access without packed increment starts one memory access on lanes
// - word data port read or write starts one full memory access
// - first wide read fetches once and returns the lowest word
// - later wide reads return next higher word, no new fetch
// - first wide read completes only after the memory access ends
// - wide transfer takes 2, 4 or 8 accesses; early writes only collect
// - last wide write gives top word and starts one assembled write
// - last wide write completes only after the memory write ends
// - packed increment turns one narrow access into several memory beats
// - data port is a 32-bit read/write register at its own offset
// - barrier writes are ignored unless barrier mode is selected
// - barrier write in barrier mode triggers a bus barrier
// - without barrier option the barrier location reads zero
// - word-only builds force the two low address bits to zero
// - address advances per increment after each narrow or word access, and after the last word of a wide one
// - banked accesses use address above bit 3 as 16-byte base
// - address low at one offset, high word at next, high resets zero
// - without wide address the high word reads zero, else it is used
// - address always targets the memory bus, never own registers
// - control word access ends a wide sequence; no partial write
// - increment field selects none, single or packed
module dmap_data_path #(
    parameter bit WIDE_ADDR = 1'b1,
    parameter bit BARRIER_EN = 1'b1,
    parameter bit SUB_WORD = 1'b1,
    parameter bit LARGE_DATA = 1'b1
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ap_valid_i,
    input wire dmap_pkg::dmap_ap_req_s ap_req_i,
    output logic ap_ready_o,
    output logic ap_done_o,
    output logic [31:0] ap_rdata_o,
    input wire logic [2:0] access_size_field_i,
    input wire logic [1:0] auto_increment_field_i,
    input wire logic [3:0] operating_mode_field_i,
    input wire logic ctrl_word_touch_i,
    output logic [63:0] banked_base_o,
    output logic mem_req_o,
    output dmap_pkg::dmap_mem_req_s mem_o,
    output logic [255:0] mem_wdata_o,
    input wire logic [255:0] mem_rdata_i,
    input wire logic mem_ack_i,
    output logic bar_req_o,
    output logic [31:0] bar_data_o,
    input wire logic bar_ack_i
);
    import dmap_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // unsupported or reserved sizes behave as word
    function automatic logic [2:0] eff_size(input logic [2:0] sz);
        logic [2:0] r;
        r = `DMAP_SIZE_WORD;
        if (sz < `DMAP_SIZE_WORD) begin
            if (SUB_WORD) begin
                r = sz;
            end
        end else if (sz <= `DMAP_SIZE_OWORD) begin
            if (LARGE_DATA) begin
                r = sz;
            end
        end
        return r;
    endfunction

    function automatic logic is_wide(input logic [2:0] sz);
        return (sz > `DMAP_SIZE_WORD);
    endfunction

    // index of the last 32-bit word of a wide value
    function automatic logic [2:0] last_word(input logic [2:0] sz);
        logic [2:0] r;
        case (sz)
            `DMAP_SIZE_DWORD: begin
                r = 3'h1;
            end
            `DMAP_SIZE_QWORD: begin
                r = 3'h3;
            end
            `DMAP_SIZE_OWORD: begin
                r = 3'h7;
            end
            default: begin
                r = 3'h0;
            end
        endcase
        return r;
    endfunction

    // byte strobes; narrow data rides the low 32-bit lanes
    function automatic logic [31:0] strobes(input logic [2:0] sz,
                                            input logic [1:0] a);
        logic [31:0] r;
        case (sz)
            `DMAP_SIZE_BYTE: begin
                r = 32'h0000_0001 << a;
            end
            `DMAP_SIZE_HALF: begin
                r = 32'h0000_0003 << {a[1], 1'b0};
            end
            `DMAP_SIZE_WORD: begin
                r = 32'h0000_000f;
            end
            `DMAP_SIZE_DWORD: begin
                r = 32'h0000_00ff;
            end
            `DMAP_SIZE_QWORD: begin
                r = 32'h0000_ffff;
            end
            default: begin
                r = 32'hffff_ffff;
            end
        endcase
        return r;
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] st);
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            r[i*8 +: 8] = {8{st[i]}};
        end
        return r;
    endfunction

    // advance the transfer address by one data item
    function automatic logic [63:0] bump(input logic [63:0] a,
                                         input logic [2:0] sz);
        logic [63:0] r;
        r = a + (64'h0000_0000_0000_0001 << sz);
        if (!WIDE_ADDR) begin
            r[63:32] = `DMAP_ADDR_HI_RST;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dmap_core_s s;
    dmap_core_s n;
    logic buf_we;
    logic buf_ld;
    logic [31:0] buf_rd;
    logic [255:0] buf_all;
    logic [2:0] take_sz;
    logic [63:0] cur_addr;
    logic [63:0] next_addr;
    logic [31:0] cur_strb;
    logic [1:0] last_beat;

    dmap_word_buf #(
        .WORDS(`DMAP_WIDE_WORDS),
        .W(32)
    ) u_buf (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .wr_en_i(buf_we),
        .wr_idx_i(s.wcnt),
        .wr_data_i(ap_req_i.wdata),
        .ld_en_i(buf_ld),
        .ld_data_i(mem_rdata_i),
        .rd_idx_i(s.wcnt),
        .rd_data_o(buf_rd),
        .all_o(buf_all)
    );

    assign take_sz = eff_size(access_size_field_i);
    assign cur_addr = {s.addr_hi, s.addr_lo};
    assign next_addr = bump(cur_addr, s.sz);
    assign cur_strb = strobes(s.sz, s.addr_lo[1:0]);
    // four byte beats or two halfword beats fill one word
    assign last_beat = (s.sz == `DMAP_SIZE_BYTE) ? 2'h3 : 2'h1;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        buf_we = 1'b0;
        buf_ld = 1'b0;
        if (ctrl_word_touch_i) begin
            n.wcnt = 3'h0;
        end
        case (s.st)
            ST_IDLE: begin
                if (ap_valid_i) begin
                    n.req = ap_req_i;
                    n.rdata = 32'h0000_0000;
                    n.beat = 2'h0;
                    n.st = ST_RESP;
                    case (ap_req_i.offset)
                        `DMAP_OFF_ADDR_LO: begin
                            if (ap_req_i.wr) begin
                                n.addr_lo = ap_req_i.wdata;
                                if (!SUB_WORD) begin
                                    n.addr_lo[1:0] = 2'h0;
                                end
                            end else begin
                                n.rdata = s.addr_lo;
                            end
                        end
                        `DMAP_OFF_ADDR_HI: begin
                            if (WIDE_ADDR) begin
                                if (ap_req_i.wr) begin
                                    n.addr_hi = ap_req_i.wdata;
                                end else begin
                                    n.rdata = s.addr_hi;
                                end
                            end
                        end
                        `DMAP_OFF_DATA_PORT: begin
                            n.sz = take_sz;
                            if (is_wide(take_sz)) begin
                                if (ap_req_i.wr) begin
                                    buf_we = 1'b1;
                                    if (s.wcnt == last_word(take_sz)) begin
                                        n.st = ST_MEM;
                                    end else begin
                                        n.wcnt = s.wcnt + 3'h1;
                                    end
                                end else if (s.wcnt == 3'h0) begin
                                    n.st = ST_MEM;
                                end else begin
                                    n.st = ST_RDW;
                                end
                            end else begin
                                buf_we = ap_req_i.wr;
                                n.st = ST_MEM;
                            end
                        end
                        `DMAP_OFF_BARRIER: begin
                            // reads return zero; bits carry no state
                            if (BARRIER_EN && ap_req_i.wr &&
                                operating_mode_field_i ==
                                `DMAP_MODE_BARRIER) begin
                                n.st = ST_BAR;
                            end
                        end
                        default: begin
                            n.st = ST_RESP;
                        end
                    endcase
                end
            end
            ST_MEM: begin
                if (mem_ack_i) begin
                    n.st = ST_RESP;
                    if (is_wide(s.sz)) begin
                        if (s.req.wr) begin
                            n.wcnt = 3'h0;
                        end else begin
                            buf_ld = 1'b1;
                            n.rdata = mem_rdata_i[31:0];
                            n.wcnt = 3'h1;
                        end
                        if (auto_increment_field_i != `DMAP_INC_OFF) begin
                            if (s.req.wr) begin
                                n.addr_lo = next_addr[31:0];
                                n.addr_hi = next_addr[63:32];
                            end
                        end
                    end else if (auto_increment_field_i ==
                                 `DMAP_INC_PACKED &&
                                 s.sz < `DMAP_SIZE_WORD) begin
                        // each beat merges its own lanes into the word
                        n.rdata = s.rdata |
                                  (mem_rdata_i[31:0] &
                                   lane_mask(cur_strb[3:0]));
                        n.addr_lo = next_addr[31:0];
                        n.addr_hi = next_addr[63:32];
                        if (s.beat != last_beat) begin
                            n.beat = s.beat + 2'h1;
                            n.st = ST_MEM;
                        end
                    end else begin
                        if (!s.req.wr) begin
                            n.rdata = mem_rdata_i[31:0];
                        end
                        if (auto_increment_field_i != `DMAP_INC_OFF) begin
                            n.addr_lo = next_addr[31:0];
                            n.addr_hi = next_addr[63:32];
                        end
                    end
                end
            end
            ST_RDW: begin
                n.rdata = buf_rd;
                n.st = ST_RESP;
                if (s.wcnt == last_word(s.sz)) begin
                    n.wcnt = 3'h0;
                    if (auto_increment_field_i != `DMAP_INC_OFF) begin
                        n.addr_lo = next_addr[31:0];
                        n.addr_hi = next_addr[63:32];
                    end
                end else begin
                    n.wcnt = s.wcnt + 3'h1;
                end
            end
            ST_BAR: begin
                if (bar_ack_i) begin
                    n.st = ST_RESP;
                end
            end
            ST_RESP: begin
                n.st = ST_IDLE;
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s.st <= ST_IDLE;
            s.addr_lo <= `DMAP_ADDR_LO_RST;
            s.addr_hi <= `DMAP_ADDR_HI_RST;
            s.wcnt <= 3'h0;
            s.beat <= 2'h0;
            s.sz <= `DMAP_SIZE_WORD;
            s.rdata <= 32'h0000_0000;
            s.req <= '0;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ap_ready_o = (s.st == ST_IDLE);
    assign ap_done_o = (s.st == ST_RESP);
    assign ap_rdata_o = s.rdata;

    // low nibble dropped so the banked window stays 16-byte aligned
    assign banked_base_o = {cur_addr[63:`DMAP_BANK_LSB],
                            4'h0};

    assign mem_req_o = (s.st == ST_MEM);
    assign mem_o.we = s.req.wr;
    assign mem_o.addr = cur_addr;
    assign mem_o.size = s.sz;
    assign mem_o.strb = cur_strb;
    assign mem_wdata_o = buf_all;

    assign bar_req_o = (s.st == ST_BAR);
    assign bar_data_o = s.req.wdata;
endmodule

// ===== hdl/dmap_consts.svh
// offsets, field codes, reset values and counts of the memory access port
`ifndef DMAP_CONSTS_SVH
`define DMAP_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets within the port's register space
// ----------------------------------------------------------------
`define DMAP_OFF_ADDR_LO 8'h04
`define DMAP_OFF_ADDR_HI 8'h08
`define DMAP_OFF_DATA_PORT 8'h0c
`define DMAP_OFF_BARRIER 8'h20

// ----------------------------------------------------------------
// access size field codes
// ----------------------------------------------------------------
`define DMAP_SIZE_BYTE 3'h0
`define DMAP_SIZE_HALF 3'h1
`define DMAP_SIZE_WORD 3'h2
`define DMAP_SIZE_DWORD 3'h3
`define DMAP_SIZE_QWORD 3'h4
`define DMAP_SIZE_OWORD 3'h5

// ----------------------------------------------------------------
// auto increment field and operating mode field codes
// ----------------------------------------------------------------
`define DMAP_INC_OFF 2'h0
`define DMAP_INC_SINGLE 2'h1
`define DMAP_INC_PACKED 2'h2
`define DMAP_MODE_BASIC 4'h0
`define DMAP_MODE_BARRIER 4'h1

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define DMAP_ADDR_LO_RST 32'h0000_0000
`define DMAP_ADDR_HI_RST 32'h0000_0000
`define DMAP_SUBWORD_LSB 2
`define DMAP_BANK_LSB 4
`define DMAP_WIDE_WORDS 8

`endif

// ===== hdl/dmap_pkg.sv
// types shared by the memory access port data path
package dmap_pkg;

    // ------------------------------------------------------------
    // register port request and memory bus request
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] offset;
        logic [31:0] wdata;
    } dmap_ap_req_s;

    typedef struct packed {
        logic we;
        logic [63:0] addr;
        logic [2:0] size;
        logic [31:0] strb;
    } dmap_mem_req_s;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_MEM,
        ST_RDW,
        ST_BAR,
        ST_RESP
    } dmap_state_e;

    typedef struct packed {
        dmap_state_e st;
        logic [31:0] addr_lo;
        logic [31:0] addr_hi;
        logic [2:0] wcnt;
        logic [1:0] beat;
        logic [2:0] sz;
        logic [31:0] rdata;
        dmap_ap_req_s req;
    } dmap_core_s;

endpackage

// ===== hdl/dmap_word_buf.sv
// word buffer that assembles and splits wide data values
`timescale 1ns/1ps
module dmap_word_buf #(
    parameter int WORDS = 8,
    parameter int W = 32
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic wr_en_i,
    input wire logic [$clog2(WORDS)-1:0] wr_idx_i,
    input wire logic [W-1:0] wr_data_i,
    input wire logic ld_en_i,
    input wire logic [WORDS*W-1:0] ld_data_i,
    input wire logic [$clog2(WORDS)-1:0] rd_idx_i,
    output logic [W-1:0] rd_data_o,
    output logic [WORDS*W-1:0] all_o
);
    typedef struct packed {
        logic [WORDS-1:0][W-1:0] mem;
        logic [W-1:0] rd;
    } buf_s;

    buf_s s;
    buf_s n;

    always_comb begin
        n = s;
        n.rd = s.mem[rd_idx_i];
        // a full load wins over a word write; they never coincide
        if (ld_en_i) begin
            n.mem = ld_data_i;
        end else if (wr_en_i) begin
            n.mem[wr_idx_i] = wr_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign rd_data_o = s.rd;
    assign all_o = s.mem;
endmodule

// ===== verification/dmap_mem_model.sv
// memory bus and barrier responder
`timescale 1ns/1ps
module dmap_mem_model (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic mem_req_i,
    input wire dmap_pkg::dmap_mem_req_s mem_i,
    input wire logic [255:0] mem_wdata_i,
    output logic [255:0] mem_rdata_o,
    output logic mem_ack_o,
    input wire logic bar_req_i,
    output logic bar_ack_o
);
    import dmap_pkg::*;
    int lat = 0;
    int cnt;
    int beats = 0;
    int bars = 0;
    logic [255:0] pat;
    logic [255:0] last_wdata;
    logic [31:0] last_strb;
    logic [63:0] last_addr;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pat[i*32 +: 32] = {8'ha0 + 8'(i), mem_i.addr[23:0]};
        end
    end
    // lat idle cycles before each answer
    assign mem_ack_o = mem_req_i && (cnt == lat);
    // lanes carry junk outside the answering cycle
    assign mem_rdata_o = mem_ack_o ? pat : ~pat;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            bar_ack_o <= 1'b0;
        end else begin
            cnt <= (mem_req_i && !mem_ack_o) ? cnt + 1 : 0;
            bar_ack_o <= bar_req_i && !bar_ack_o;
            if (bar_req_i && bar_ack_o) begin
                bars <= bars + 1;
            end
            if (mem_ack_o) begin
                beats <= beats + 1;
                last_addr <= mem_i.addr;
                last_strb <= mem_i.strb;
                last_wdata <= mem_wdata_i;
            end
        end
    end
endmodule

// ===== verification/dmap_data_path_checker.sv
// assertions on the port's handshakes, word strobes and banked base alignment
`timescale 1ns/1ps
`include "dmap_consts.svh"
module dmap_data_path_checker #(
    parameter bit BARRIER_EN = 1'b1
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ap_valid_i,
    input wire dmap_pkg::dmap_ap_req_s ap_req_i,
    input wire logic ap_ready_o,
    input wire logic ap_done_o,
    input wire logic [3:0] operating_mode_field_i,
    input wire logic [63:0] banked_base_o,
    input wire logic mem_req_o,
    input wire dmap_pkg::dmap_mem_req_s mem_o,
    input wire logic mem_ack_i,
    input wire logic bar_req_o,
    input wire logic bar_ack_i
);
    import dmap_pkg::*;
    logic take;
    logic bar_wr;
    assign take = ap_valid_i && ap_ready_o;
    assign bar_wr = take && ap_req_i.wr
        && ap_req_i.offset == `DMAP_OFF_BARRIER;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_finish;
        ap_done_o ##1 (ap_ready_o && !ap_done_o);
    endsequence
    a_busy_after_take: assert property (take |=> !ap_ready_o)
        else $error("ready after take");
    a_no_early_done: assert property (ap_done_o |-> !mem_req_o)
        else $error("early done");
    a_ack_ends_beat: assert property (mem_req_o && mem_ack_i
        |=> ap_done_o || mem_req_o)
        else $error("ack lost");
    a_beat_held: assert property (mem_req_o && !mem_ack_i
        |=> mem_req_o && $stable(mem_o))
        else $error("beat changed");
    a_word_strobe: assert property (mem_req_o
        && mem_o.size == `DMAP_SIZE_WORD |-> mem_o.strb == 32'h0000_000f)
        else $error("word strobe");
    a_bank_base: assert property (banked_base_o[3:0] == 4'h0)
        else $error("bank base");
    a_bar_ignored: assert property (bar_wr
        && operating_mode_field_i != `DMAP_MODE_BARRIER
        |=> ap_done_o && !bar_req_o)
        else $error("barrier not ignored");
    a_bar_raised: assert property (bar_wr && BARRIER_EN
        && operating_mode_field_i == `DMAP_MODE_BARRIER
        |-> ##[1:2] bar_req_o)
        else $error("barrier not raised");
    a_bar_done: assert property (bar_req_o && bar_ack_i
        |=> ap_done_o && !bar_req_o)
        else $error("barrier not done");
    a_addr_write: assert property (take
        && ap_req_i.offset == `DMAP_OFF_ADDR_LO |=> s_finish)
        else $error("address access slow");
endmodule
bind dmap_data_path dmap_data_path_checker #(
    .BARRIER_EN(BARRIER_EN)
) chk_inst (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ap_valid_i(ap_valid_i),
    .ap_req_i(ap_req_i),
    .ap_ready_o(ap_ready_o),
    .ap_done_o(ap_done_o),
    .operating_mode_field_i(operating_mode_field_i),
    .banked_base_o(banked_base_o),
    .mem_req_o(mem_req_o),
    .mem_o(mem_o),
    .mem_ack_i(mem_ack_i),
    .bar_req_o(bar_req_o),
    .bar_ack_i(bar_ack_i)
);

// ===== verification/debug_memory_access_data_path_tb.sv
// self-checking bench for the port's data, address and barrier path
`timescale 1ns/1ps
`include "dmap_consts.svh"
module debug_memory_access_data_path_tb;
    import dmap_pkg::*;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ap_valid_i = 1'b0;
    dmap_ap_req_s ap_req_i = '0;
    logic ap_ready_o, ap_done_o, mem_req_o, mem_ack_i, bar_req_o, bar_ack_i;
    logic [31:0] ap_rdata_o, bar_data_o, r;
    logic [2:0] sz = 3'h2;
    logic [1:0] inc = 2'h0;
    logic [3:0] mode = 4'h0;
    logic touch = 1'b0;
    logic [63:0] banked_base_o;
    dmap_mem_req_s mem_o;
    logic [255:0] mem_wdata_o, mem_rdata_i;
    int fails = 0;
    int check_count = 0;
    int b0;
    always #2 mclk_i = ~mclk_i;
    dmap_data_path dmap_data_path_inst (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .ap_valid_i(ap_valid_i),
        .ap_req_i(ap_req_i), .ap_ready_o(ap_ready_o), .ap_done_o(ap_done_o),
        .ap_rdata_o(ap_rdata_o), .access_size_field_i(sz),
        .auto_increment_field_i(inc), .operating_mode_field_i(mode),
        .ctrl_word_touch_i(touch), .banked_base_o(banked_base_o),
        .mem_req_o(mem_req_o), .mem_o(mem_o), .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
        .bar_req_o(bar_req_o), .bar_data_o(bar_data_o), .bar_ack_i(bar_ack_i)
    );
    dmap_mem_model mem_model_inst (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .mem_req_i(mem_req_o),
        .mem_i(mem_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
        .mem_ack_o(mem_ack_i), .bar_req_i(bar_req_o), .bar_ack_o(bar_ack_i)
    );
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one-edge request, bounded wait for done
    task automatic acc(input logic wr, input logic [7:0] off,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(negedge mclk_i);
        ap_valid_i = 1'b1;
        ap_req_i = {wr, off, wd};
        @(negedge mclk_i);
        ap_valid_i = 1'b0;
        while (ap_done_o !== 1'b1 && n < 50) begin
            @(negedge mclk_i);
            n++;
        end
        if (n == 50) fails++;
        r = ap_rdata_o;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        acc(0, `DMAP_OFF_ADDR_HI, 0); chk(r, 0);
        acc(1, `DMAP_OFF_ADDR_HI, 32'h0000_0001);
        acc(0, `DMAP_OFF_ADDR_HI, 0); chk(r, 1);
        acc(1, `DMAP_OFF_ADDR_HI, 0);
        acc(1, `DMAP_OFF_ADDR_LO, 32'h1234_5678);
        acc(0, `DMAP_OFF_ADDR_LO, 0); chk(r, 32'h1234_5678);
        chk(banked_base_o, 64'h0000_0000_1234_5670);
        acc(0, `DMAP_OFF_BARRIER, 0); chk(r, 0);
    endtask
    task automatic t_word();
        sz = `DMAP_SIZE_WORD;
        inc = `DMAP_INC_SINGLE;
        acc(1, `DMAP_OFF_ADDR_LO, 32'h0000_0100);
        acc(1, `DMAP_OFF_DATA_PORT, 32'hcafe_f00d);
        chk(mem_model_inst.last_addr, 64'h100);
        chk(mem_model_inst.last_strb, 32'h0000_000f);
        chk(mem_model_inst.last_wdata[31:0], 32'hcafe_f00d);
        mem_model_inst.lat = 3;
        acc(1, `DMAP_OFF_ADDR_LO, 32'h0000_0104);
        acc(0, `DMAP_OFF_DATA_PORT, 0); chk(r, 32'ha000_0104);
        acc(0, `DMAP_OFF_ADDR_LO, 0); chk(r, 32'h0000_0108);
        inc = `DMAP_INC_OFF;
        acc(0, `DMAP_OFF_DATA_PORT, 0);
        acc(0, `DMAP_OFF_ADDR_LO, 0); chk(r, 32'h0000_0108);
        mem_model_inst.lat = 0;
    endtask
    task automatic t_narrow();
        sz = `DMAP_SIZE_BYTE;
        inc = `DMAP_INC_PACKED;
        acc(1, `DMAP_OFF_ADDR_LO, 32'h0000_0200);
        b0 = mem_model_inst.beats;
        acc(1, `DMAP_OFF_DATA_PORT, 32'h4433_2211);
        chk(64'(mem_model_inst.beats - b0), 4);
        acc(0, `DMAP_OFF_ADDR_LO, 0); chk(r, 32'h0000_0204);
        sz = `DMAP_SIZE_HALF;
        b0 = mem_model_inst.beats;
        acc(1, `DMAP_OFF_DATA_PORT, 32'h4433_2211);
        chk(64'(mem_model_inst.beats - b0), 2);
        inc = `DMAP_INC_SINGLE;
        acc(1, `DMAP_OFF_ADDR_LO, 32'h0000_0202);
        acc(1, `DMAP_OFF_DATA_PORT, 32'hbeef_0000);
        chk(mem_model_inst.last_strb, 32'h0000_000c);
        sz = `DMAP_SIZE_BYTE;
        acc(1, `DMAP_OFF_ADDR_LO, 32'h0000_0201);
        acc(1, `DMAP_OFF_DATA_PORT, 32'h0000_ab00);
        chk(mem_model_inst.last_strb, 32'h0000_0002);
        chk(mem_model_inst.last_wdata[31:0], 32'h0000_ab00);
    endtask
    task automatic t_wide_read();
        inc = `DMAP_INC_OFF;
        acc(1, `DMAP_OFF_ADDR_LO, 32'h0000_0300);
        for (int s = 3; s <= 5; s++) begin
            sz = 3'(s);
            b0 = mem_model_inst.beats;
            for (int i = 0; i < (1 << (s - 2)); i++) begin
                acc(0, `DMAP_OFF_DATA_PORT, 0);
                chk(r, {8'ha0 + 8'(i), 24'h00_0300});
            end
            chk(64'(mem_model_inst.beats - b0), 1);
        end
    endtask
    task automatic t_wide_write();
        sz = `DMAP_SIZE_QWORD;
        inc = `DMAP_INC_SINGLE;
        acc(1, `DMAP_OFF_ADDR_LO, 32'h0000_0400);
        b0 = mem_model_inst.beats;
        acc(1, `DMAP_OFF_DATA_PORT, 32'h5500_0000);
        acc(1, `DMAP_OFF_DATA_PORT, 32'h5500_0001);
        @(negedge mclk_i);
        touch = 1'b1;
        @(negedge mclk_i);
        touch = 1'b0;
        for (int i = 0; i < 4; i++) begin
            chk(64'(mem_model_inst.beats - b0), 0);
            acc(1, `DMAP_OFF_DATA_PORT, 32'h7700_0000 + 32'(i));
        end
        chk(64'(mem_model_inst.beats - b0), 1);
        chk(mem_model_inst.last_wdata[127:64], 64'h7700_0003_7700_0002);
        chk(mem_model_inst.last_wdata[63:0], 64'h7700_0001_7700_0000);
        chk(mem_model_inst.last_strb, 32'h0000_ffff);
        acc(0, `DMAP_OFF_ADDR_LO, 0); chk(r, 32'h0000_0410);
    endtask
    task automatic t_barrier();
        b0 = mem_model_inst.bars;
        mode = `DMAP_MODE_BASIC;
        acc(1, `DMAP_OFF_BARRIER, 32'h0000_00a5);
        chk(64'(mem_model_inst.bars - b0), 0);
        mode = `DMAP_MODE_BARRIER;
        acc(1, `DMAP_OFF_BARRIER, 32'h0000_005a);
        chk(64'(mem_model_inst.bars - b0), 1);
        chk(bar_data_o, 32'h0000_005a);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge mclk_i);
        @(negedge mclk_i);
        nrst_i = 1'b1;
        t_regs();
        t_word();
        t_narrow();
        t_wide_read();
        t_wide_write();
        t_barrier();
        give_verdict();
    end
    // run needs under 2000 cycles
    initial begin
        #80000;
        fails++;
        give_verdict();
    end
endmodule
